// *** pcs_defines.svh ***
// Constants for the gigabit serial PCS sublayer
// Assumes a 40 MHz core clock and an 8-bit transceiver code path
`ifndef PCS_DEFINES_SVH
`define PCS_DEFINES_SVH
`define K28_5        8'hbc
`define D16_2        8'h50
`define D21_5        8'hb5
`define D2_2         8'h42
`define K_SOP        8'hfb
`define K_EOP        8'hfd
`define K_CAR        8'hf7
`define K_ERR        8'hfe
`define RX_PREAMBLE  8'h55
`define CLK_NS       25
`define LT_UNIT_NS   32768
`define LT_UNIT_CYC  (`LT_UNIT_NS / `CLK_NS)
`define LT_DEFAULT   9'h13d
`define SYNC_COMMAS  2'h3
`define SYNC_BAD     3'h4
`define SYNC_GOOD    2'h3
`define REG_CTRL     5'h00
`define REG_STAT     5'h01
`define REG_ADV      5'h04
`define REG_LP       5'h05
`define CTRL_RST     15
`define CTRL_ANEN    12
`define CTRL_RESTART 9
`define CTRL_RESET   16'h1140
`define ADV_RESET    16'h0020
`define CFG_ACK      14
`define MD_PHYAD     5'h01
`endif

// *** pcs_pkg.sv ***
// Types shared by the PCS sublayer
// Assumes pcs_defines.svh holds all numeric constants
package pcs_pkg;
	typedef enum logic [2:0] {TX_IDLE, TX_SOP, TX_DATA, TX_EOP, TX_CAR, TX_CFG} pcs_tx_t;
	typedef enum logic [1:0] {SY_LOSS, SY_ACQ, SY_OK} pcs_sync_t;
	typedef enum logic [2:0] {AN_OFF, AN_RESTART, AN_ABIL, AN_ACK, AN_CACK, AN_IDLE,
		AN_LINK} pcs_an_t;
endpackage : pcs_pkg

// *** pcs_sublayer.sv ***
// PCS sublayer: transmit FIFO, ordered sets, sync, receive decode, MDIO, autoneg
// Assumes the transceiver codes 8B/10B and shares core_clk; MDIO pins are async
`timescale 1ns/10ps
`include "pcs_defines.svh"

module pcs_fifo #(parameter int W = 9, parameter int D = 8) (
	input  wire logic         core_clk,
	input  wire logic         rst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW:0]  wr_r;
	logic [AW:0]  rd_r;
	assign out_valid = wr_r != rd_r;
	assign in_ready  = (wr_r[AW] == rd_r[AW]) || (wr_r[AW-1:0] != rd_r[AW-1:0]);
	assign out_data  = mem[rd_r[AW-1:0]];
	always_ff @(posedge core_clk) begin
		if (in_valid && in_ready) mem[wr_r[AW-1:0]] <= in_data;
	end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) wr_r <= '0;
		else if (in_valid && in_ready) wr_r <= wr_r + 1'b1;
	end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) rd_r <= '0;
		else if (out_valid && out_ready) rd_r <= rd_r + 1'b1;
	end
	chk_fifo_full: assert property (@(posedge core_clk) disable iff (rst)
		(wr_r - rd_r) == D[AW:0] |-> !in_ready) else $error("fifo accepts when full");
endmodule : pcs_fifo

module pcs_sublayer
	import pcs_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       clocks_locked_in,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_last,
	input  wire logic       tx_valid,
	output logic            tx_ready,
	output logic [7:0]      tx_code,
	output logic            tx_is_k,
	input  wire logic [7:0] rx_code,
	input  wire logic       rx_is_k,
	input  wire logic       rx_code_err,
	output logic [7:0]      rx_data,
	output logic            rx_dv,
	output logic            rx_er,
	output logic            link_ok,
	input  wire logic [8:0] link_timer_setting,
	input  wire logic       mdc,
	input  wire logic       mdio_in,
	output logic            mdio_out,
	output logic            mdio_oe_n
);
	import pcs_pkg::*;
	logic lk_s1_r, lk_s2_r, core_rst;
	pcs_tx_t tx_st_r;
	pcs_sync_t sy_st_r;
	pcs_an_t an_st_r, an_nxt;
	logic f_valid, f_ready, f_last, pos_r, cfg_alt_r, rx_comma, rx_inv;
	logic [7:0] f_data, tx_code_r;
	logic [1:0] cfg_idx_r, sy_cnt_r, good_r;
	logic [2:0] bad_r;
	logic tx_is_k_r, rx_dv_r, rx_er_r, prev_comma_r, rx_cfg_stb_r, an_done_r;
	logic [7:0] rx_data_r, cfg_lo_r;
	logic [1:0] rx_cfg_cnt_r;
	logic [15:0] rx_cfg_r, ctrl_r, adv_r, lp_r, tx_cfg;
	logic [10:0] lt_cyc_r;
	logic [8:0] lt_units_r;
	logic lt_done, an_en, an_kick, phy_rst_p, restart_p, sync_ok;
	logic md_c1_r, md_c2_r, md_c3_r, md_d1_r, md_d2_r, md_rise, md_rd_r, md_me_r;
	logic md_drv_r, md_out_r;
	logic [4:0] md_cnt_r, md_reg_r;
	logic [15:0] md_sr_r, md_q_r;

	// Clocks-locked holds everything but the lock and MDIO input synchronisers in reset
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) {lk_s1_r, lk_s2_r} <= 2'b00;
		else {lk_s1_r, lk_s2_r} <= {clocks_locked_in, lk_s1_r};
	end
	assign core_rst = rst || !lk_s2_r;

	pcs_fifo #(.W(9), .D(8)) u_fifo (
		.core_clk (core_clk),
		.rst      (core_rst),
		.in_valid (tx_valid),
		.in_ready (tx_ready),
		.in_data  ({tx_last, tx_data}),
		.out_valid(f_valid),
		.out_ready(f_ready),
		.out_data ({f_last, f_data})
	);
	assign f_ready = tx_st_r == TX_DATA;

	// Transmit ordered-set engine; idle and config start on even positions
	assign tx_cfg = an_st_r == AN_RESTART ? 16'h0000 :
		an_st_r == AN_ACK ? (adv_r | (16'h0001 << `CFG_ACK)) : adv_r;
	wire xmit_cfg = an_st_r inside {AN_RESTART, AN_ABIL, AN_ACK, AN_CACK};
	always_ff @(posedge core_clk or posedge core_rst) begin
		if (core_rst) begin
			tx_st_r <= TX_IDLE;
			pos_r <= 1'b0;
			cfg_idx_r <= 2'h0;
			cfg_alt_r <= 1'b0;
		end else begin
			pos_r <= !pos_r;
			cfg_idx_r <= tx_st_r == TX_CFG ? cfg_idx_r + 2'h1 : 2'h0;
			if (tx_st_r == TX_CFG && cfg_idx_r == 2'h3) cfg_alt_r <= !cfg_alt_r;
			case (tx_st_r)
				TX_IDLE: if (pos_r) tx_st_r <= xmit_cfg ? TX_CFG : f_valid ? TX_SOP : TX_IDLE;
				TX_SOP:  tx_st_r <= TX_DATA;
				TX_DATA: if (!f_valid || f_last) tx_st_r <= TX_EOP;
				TX_EOP:  tx_st_r <= TX_CAR;
				TX_CAR:  if (pos_r) tx_st_r <= TX_IDLE;
				TX_CFG:  if (cfg_idx_r == 2'h3 && !xmit_cfg) tx_st_r <= TX_IDLE;
				default: tx_st_r <= TX_IDLE;
			endcase
		end
	end
	always_ff @(posedge core_clk or posedge core_rst) begin
		if (core_rst) begin
			tx_code_r <= `K28_5;
			tx_is_k_r <= 1'b1;
		end else begin
			case (tx_st_r)
				TX_SOP:  {tx_is_k_r, tx_code_r} <= {1'b1, `K_SOP};
				TX_DATA: {tx_is_k_r, tx_code_r} <= f_valid ? {1'b0, f_data} : {1'b1, `K_ERR};
				TX_EOP:  {tx_is_k_r, tx_code_r} <= {1'b1, `K_EOP};
				TX_CAR:  {tx_is_k_r, tx_code_r} <= {1'b1, `K_CAR};
				TX_CFG: begin
					case (cfg_idx_r)
						2'h0: {tx_is_k_r, tx_code_r} <= {1'b1, `K28_5};
						2'h1: {tx_is_k_r, tx_code_r} <= {1'b0, cfg_alt_r ? `D2_2 : `D21_5};
						2'h2: {tx_is_k_r, tx_code_r} <= {1'b0, tx_cfg[7:0]};
						default: {tx_is_k_r, tx_code_r} <= {1'b0, tx_cfg[15:8]};
					endcase
				end
				default: {tx_is_k_r, tx_code_r} <= pos_r ? {1'b0, `D16_2} : {1'b1, `K28_5};
			endcase
		end
	end
	assign tx_code = tx_code_r;
	assign tx_is_k = tx_is_k_r;
	chk_tx_sop_code: assert property (@(posedge core_clk) disable iff (core_rst)
		tx_st_r == TX_SOP |=> tx_is_k && tx_code == `K_SOP) else $error("bad start code");
	chk_tx_end_seq: assert property (@(posedge core_clk) disable iff (core_rst)
		tx_st_r == TX_EOP |=> tx_code == `K_EOP ##1 tx_code == `K_CAR) else $error("bad end");
	chk_lock_hold: assert property (@(posedge core_clk) disable iff (rst)
		!lk_s2_r |-> tx_st_r == TX_IDLE && sy_st_r == SY_LOSS) else $error("runs unlocked");

	// Synchronization: three commas to acquire, four net bad groups to lose
	assign rx_comma = rx_is_k && rx_code == `K28_5;
	assign rx_inv = rx_code_err || (rx_is_k && !(rx_code inside {`K28_5, `K_SOP, `K_EOP,
		`K_CAR, `K_ERR}));
	always_ff @(posedge core_clk or posedge core_rst) begin
		if (core_rst) begin
			sy_st_r <= SY_LOSS;
			sy_cnt_r <= 2'h0;
			bad_r <= 3'h0;
			good_r <= 2'h0;
		end else begin
			case (sy_st_r)
				SY_LOSS: if (rx_comma) {sy_st_r, sy_cnt_r} <= {SY_ACQ, 2'h1};
				SY_ACQ: begin
					if (rx_inv) sy_st_r <= SY_LOSS;
					else if (rx_comma) sy_cnt_r <= sy_cnt_r + 2'h1;
					if (!rx_inv && rx_comma && sy_cnt_r == `SYNC_COMMAS - 2'h1) begin
						{sy_st_r, bad_r, good_r} <= {SY_OK, 3'h0, 2'h0};
					end
				end
				SY_OK: begin
					if (rx_inv) begin
						bad_r <= bad_r + 3'h1;
						good_r <= 2'h0;
						if (bad_r == `SYNC_BAD - 3'h1) sy_st_r <= SY_LOSS;
					end else if (bad_r != 3'h0) begin
						good_r <= good_r == `SYNC_GOOD ? 2'h0 : good_r + 2'h1;
						if (good_r == `SYNC_GOOD) bad_r <= bad_r - 3'h1;
					end
				end
				default: sy_st_r <= SY_LOSS;
			endcase
		end
	end
	assign sync_ok = sy_st_r == SY_OK;
	chk_sync_loss: assert property (@(posedge core_clk) disable iff (core_rst)
		sync_ok && rx_inv && bad_r == 3'h3 |=> sy_st_r == SY_LOSS) else $error("no loss");
	chk_sync_acq: assert property (@(posedge core_clk) disable iff (core_rst)
		sy_st_r == SY_LOSS |=> !sync_ok) else $error("sync without commas");

	// Receive decode of frames and configuration ordered sets
	always_ff @(posedge core_clk or posedge core_rst) begin
		if (core_rst) begin
			{rx_dv_r, rx_er_r, prev_comma_r, rx_cfg_stb_r} <= 4'h0;
			{rx_data_r, cfg_lo_r, rx_cfg_cnt_r, rx_cfg_r} <= '0;
		end else begin
			prev_comma_r <= rx_comma;
			rx_cfg_stb_r <= 1'b0;
			rx_er_r <= 1'b0;
			if (prev_comma_r && !rx_is_k && rx_code inside {`D21_5, `D2_2}) rx_cfg_cnt_r <= 2'h2;
			else if (rx_cfg_cnt_r != 2'h0) rx_cfg_cnt_r <= rx_cfg_cnt_r - 2'h1;
			if (rx_cfg_cnt_r == 2'h2) cfg_lo_r <= rx_code;
			if (rx_cfg_cnt_r == 2'h1) {rx_cfg_stb_r, rx_cfg_r} <= {1'b1, rx_code, cfg_lo_r};
			if (!sync_ok) rx_dv_r <= 1'b0;
			else if (!rx_dv_r) begin
				if (rx_is_k && rx_code == `K_SOP) {rx_dv_r, rx_data_r} <= {1'b1, `RX_PREAMBLE};
			end else if (rx_is_k && rx_code == `K_EOP) rx_dv_r <= 1'b0;
			else begin
				rx_data_r <= rx_code;
				rx_er_r <= rx_is_k || rx_code_err;
			end
		end
	end
	assign rx_data = rx_data_r;
	assign rx_dv = rx_dv_r;
	assign rx_er = rx_er_r;
	chk_rx_start: assert property (@(posedge core_clk) disable iff (core_rst)
		sync_ok && !rx_dv && rx_is_k && rx_code == `K_SOP |=> rx_dv && rx_data == `RX_PREAMBLE)
		else $error("start not decoded");

	// Link timer counts units of the scaled reference period
	always_ff @(posedge core_clk or posedge core_rst) begin
		if (core_rst) {lt_cyc_r, lt_units_r} <= '0;
		else if (an_nxt != an_st_r) {lt_cyc_r, lt_units_r} <= '0;
		else if (!lt_done) begin
			lt_cyc_r <= lt_cyc_r == 11'(`LT_UNIT_CYC - 1) ? 11'h0 : lt_cyc_r + 11'h1;
			if (lt_cyc_r == 11'(`LT_UNIT_CYC - 1)) lt_units_r <= lt_units_r + 9'h1;
		end
	end
	assign lt_done = lt_units_r >= link_timer_setting;

	// Autonegotiation sequencing
	assign an_en = ctrl_r[`CTRL_ANEN];
	assign an_kick = restart_p || phy_rst_p || (an_st_r != AN_RESTART && !sync_ok);
	always_comb begin
		an_nxt = an_st_r;
		case (an_st_r)
			AN_OFF:     an_nxt = AN_RESTART;
			AN_RESTART: if (lt_done) an_nxt = AN_ABIL;
			AN_ABIL:    if (rx_cfg_stb_r && rx_cfg_r != 16'h0000) an_nxt = AN_ACK;
			AN_ACK:     if (rx_cfg_stb_r && rx_cfg_r[`CFG_ACK]) an_nxt = AN_CACK;
			AN_CACK:    if (lt_done) an_nxt = AN_IDLE;
			AN_IDLE:    if (lt_done) an_nxt = AN_LINK;
			AN_LINK:    if (rx_cfg_stb_r) an_nxt = AN_RESTART;
			default:    an_nxt = AN_OFF;
		endcase
		if (an_kick) an_nxt = AN_RESTART;
		if (!an_en) an_nxt = AN_OFF;
	end
	always_ff @(posedge core_clk or posedge core_rst) begin
		if (core_rst) an_st_r <= AN_OFF;
		else an_st_r <= an_nxt;
	end
	always_ff @(posedge core_clk or posedge core_rst) begin
		if (core_rst) {lp_r, an_done_r} <= '0;
		else begin
			if (an_st_r == AN_ABIL && rx_cfg_stb_r && rx_cfg_r != 16'h0000) lp_r <= rx_cfg_r;
			an_done_r <= an_st_r == AN_LINK;
		end
	end
	assign link_ok = sync_ok && (!an_en || an_done_r);
	chk_an_restart: assert property (@(posedge core_clk) disable iff (core_rst)
		an_en && restart_p |=> an_st_r == AN_RESTART) else $error("restart ignored");
	chk_lt_length: assert property (@(posedge core_clk) disable iff (core_rst)
		$rose(lt_done) |-> lt_units_r == link_timer_setting) else $error("timer length");
	chk_lp_capture: assert property (@(posedge core_clk) disable iff (core_rst)
		an_st_r == AN_ABIL && an_nxt == AN_ACK |=> lp_r == $past(rx_cfg_r))
		else $error("partner word lost");

	// MDIO management slave, sampled through two flops
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) {md_c1_r, md_c2_r, md_c3_r, md_d1_r, md_d2_r} <= 5'h0;
		else {md_c1_r, md_c2_r, md_c3_r, md_d1_r, md_d2_r} <= {mdc, md_c1_r, md_c2_r,
			mdio_in, md_d1_r};
	end
	assign md_rise = md_c2_r && !md_c3_r;
	always_ff @(posedge core_clk or posedge core_rst) begin
		if (core_rst) begin
			{md_cnt_r, md_reg_r, md_sr_r, md_q_r, md_rd_r, md_me_r, md_drv_r, md_out_r} <= '0;
			{restart_p, phy_rst_p} <= 2'b00;
			ctrl_r <= `CTRL_RESET;
			adv_r <= `ADV_RESET;
		end else begin
			{restart_p, phy_rst_p} <= 2'b00;
			if (md_rise) begin
				md_sr_r <= {md_sr_r[14:0], md_d2_r};
				md_cnt_r <= (md_cnt_r == 5'h0 && !(md_d2_r && !md_sr_r[0])) ? 5'h0 :
					md_cnt_r == 5'd30 ? 5'h0 : md_cnt_r + 5'h1;
				md_out_r <= md_q_r[15];
				md_q_r <= {md_q_r[14:0], 1'b0};
				if (md_cnt_r == 5'd12) begin
					md_rd_r <= md_sr_r[10];
					md_me_r <= {md_sr_r[8:5], md_sr_r[4]} == `MD_PHYAD;
					md_reg_r <= {md_sr_r[3:0], md_d2_r};
				end
				if (md_cnt_r == 5'd13 && md_rd_r && md_me_r) begin
					md_drv_r <= 1'b1;
					md_out_r <= 1'b0;
					case (md_reg_r)
						`REG_CTRL: md_q_r <= ctrl_r;
						`REG_STAT: md_q_r <= {10'h000, an_done_r, 2'b01, link_ok, 2'b00};
						`REG_ADV:  md_q_r <= adv_r;
						`REG_LP:   md_q_r <= lp_r;
						default:   md_q_r <= 16'h0000;
					endcase
				end
				if (md_cnt_r == 5'd30) md_drv_r <= 1'b0;
				if (md_cnt_r == 5'd30 && !md_rd_r && md_me_r) begin
					if (md_reg_r == `REG_CTRL) begin
						ctrl_r <= {1'b0, md_sr_r[13:9], 1'b0, md_sr_r[7:0], md_d2_r};
						restart_p <= md_sr_r[8];
						phy_rst_p <= md_sr_r[14];
					end
					if (md_reg_r == `REG_ADV) adv_r <= {md_sr_r[14:0], md_d2_r};
				end
			end
		end
	end
	assign mdio_out = md_out_r;
	assign mdio_oe_n = !md_drv_r;
	chk_mdio_turn: assert property (@(posedge core_clk) disable iff (core_rst)
		md_rise && md_cnt_r == 5'd13 && md_rd_r && md_me_r |=> !mdio_oe_n && !mdio_out)
		else $error("turnaround not driven");
endmodule : pcs_sublayer

// *** pcs_sublayer_tb.sv ***
// Testbench: random frames both ways, MDIO access, sync and lock handling
// Assumes pcs_xcvr_model stands on the transceiver side
`timescale 1ns/10ps
`include "pcs_defines.svh"
module pcs_sublayer_tb;
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic        clocks_locked_in;
	logic [7:0]  tx_data = 8'h00;
	logic        tx_last = 1'b0;
	logic        tx_valid = 1'b0;
	logic        tx_ready, tx_is_k, rx_is_k, rx_code_err, rx_dv, rx_er, link_ok;
	logic [7:0]  tx_code, rx_code, rx_data;
	logic        mdc = 1'b0;
	logic        mdio_host = 1'b1;
	logic        mdio_in, mdio_out, mdio_oe_n;
	int          miscompares = 0;
	int          num_checks = 0;
	int          seed = 75498;
	logic [15:0] rd;
	logic [7:0]  fr[$];
	always #12.5 core_clk = ~core_clk;
	assign mdio_in = mdio_oe_n ? mdio_host : mdio_out;
	pcs_sublayer pcs_sublayer_i (.core_clk(core_clk), .rst(rst),
		.clocks_locked_in(clocks_locked_in), .tx_data(tx_data), .tx_last(tx_last),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_code(tx_code), .tx_is_k(tx_is_k),
		.rx_code(rx_code), .rx_is_k(rx_is_k), .rx_code_err(rx_code_err), .rx_data(rx_data),
		.rx_dv(rx_dv), .rx_er(rx_er), .link_ok(link_ok), .link_timer_setting(9'h001),
		.mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n));
	// One shared clock only: no half-rate or unused clock pins exist here
	pcs_xcvr_model pcs_xcvr_model_i (.core_clk(core_clk), .rx_code(rx_code),
		.rx_is_k(rx_is_k), .rx_code_err(rx_code_err), .pll_lock(clocks_locked_in));
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic tally_and_finish();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : tally_and_finish
	task automatic hang(input string what);
		check(what, 16'h0000, 16'h0001);
		tally_and_finish();
	endtask : hang
	task automatic mdc_bit(input logic b, output logic s);
		mdc <= 1'b0;
		mdio_host <= b;
		repeat (5) @(posedge core_clk);
		s = mdio_in;
		mdc <= 1'b1;
		repeat (5) @(posedge core_clk);
	endtask : mdc_bit
	task automatic mdio(input logic rop, input logic [4:0] ra, input logic [15:0] wd,
		output logic [15:0] rdat);
		logic [63:0] f;
		logic        s;
		f = {32'hffffffff, 2'b01, rop ? 2'b10 : 2'b01, `MD_PHYAD, ra,
			rop ? 18'h3ffff : {2'b10, wd}};
		@(posedge core_clk);
		for (int i = 65; i >= 0; i--) begin
			mdc_bit(i >= 2 ? f[i - 2] : 1'b1, s);
			if (i >= 2 && i < 18) begin
				rdat[i - 2] = s;
			end
		end
	endtask : mdio
	task automatic push(input logic [7:0] b, input logic last);
		int n = 0;
		tx_data <= b;
		tx_last <= last;
		tx_valid <= 1'b1;
		do @(posedge core_clk); while (tx_ready !== 1'b1 && ++n < 60);
		if (n >= 60) hang("push");
	endtask : push
	task automatic tx_expect(input logic trunc);
		int n = 0;
		do @(negedge core_clk); while (!(tx_is_k === 1'b1 && tx_code === `K_SOP) && ++n < 2000);
		if (n >= 2000) hang("tx start");
		foreach (fr[i]) begin
			@(negedge core_clk);
			check("tx byte", {tx_is_k, tx_code}, {1'b0, fr[i]});
		end
		@(negedge core_clk);
		if (trunc) begin
			check("tx abort", {tx_is_k, tx_code}, {1'b1, `K_ERR});
			@(negedge core_clk);
		end
		check("tx end", {tx_is_k, tx_code}, {1'b1, `K_EOP});
	endtask : tx_expect
	task automatic new_frame(input int len);
		fr = {};
		for (int i = 0; i < len; i++) fr.push_back(8'($random(seed)));
	endtask : new_frame
	task automatic rx_frame(input int len, input int bad);
		int n = 0;
		new_frame(len);
		pcs_xcvr_model_i.put(`K_SOP, 1'b1, 1'b0);
		foreach (fr[i]) pcs_xcvr_model_i.put(fr[i], 1'b0, i == bad);
		pcs_xcvr_model_i.put(`K_EOP, 1'b1, 1'b0);
		pcs_xcvr_model_i.put(`K_CAR, 1'b1, 1'b0);
		do @(negedge core_clk); while (rx_dv !== 1'b1 && ++n < 20);
		if (n >= 20) hang("rx start");
		check("rx preamble", rx_data, `RX_PREAMBLE);
		foreach (fr[i]) begin
			@(negedge core_clk);
			check("rx flags", {rx_er, rx_dv}, {i == bad, 1'b1});
			if (i != bad) check("rx byte", rx_data, fr[i]);
		end
		@(negedge core_clk);
		check("rx end", rx_dv, 1'b0);
	endtask : rx_frame
	initial begin
		int n;
		repeat (12) @(posedge core_clk);
		check("reset code", {tx_is_k, tx_code}, {1'b1, `K28_5});
		check("reset outs", {rx_dv, rx_er, mdio_oe_n, link_ok}, 4'b0010);
		rst <= 1'b0;
		repeat (20) @(posedge core_clk);
		check("unlocked", {tx_ready, tx_is_k, tx_code}, {2'b11, `K28_5});
		pcs_xcvr_model_i.set_lock(1'b1);
		n = 0;
		do @(negedge core_clk); while (!(tx_is_k === 1'b0 && (tx_code === `D21_5 ||
			tx_code === `D2_2)) && ++n < 100);
		check("config sent", n < 100, 1'b1);
		check("no link in autoneg", link_ok, 1'b0);
		new_frame(8);
		@(posedge core_clk);
		foreach (fr[i]) push(fr[i], 1'b0);
		tx_valid <= 1'b0;
		@(negedge core_clk);
		check("fifo full", tx_ready, 1'b0);
		fork
			mdio(1'b0, `REG_CTRL, 16'h0000, rd);
			tx_expect(1'b1);
		join
		$display("done fill and abort");
		mdio(1'b1, `REG_CTRL, 16'h0000, rd);
		check("ctrl", rd, 16'h0000);
		mdio(1'b1, `REG_ADV, 16'h0000, rd);
		check("adv", rd, `ADV_RESET);
		mdio(1'b1, 5'h02, 16'h0000, rd);
		check("unmapped", rd, 16'h0000);
		mdio(1'b1, `REG_STAT, 16'h0000, rd);
		check("status", rd[3:2], 2'b11);
		check("link", link_ok, 1'b1);
		n = 0;
		do @(negedge core_clk); while (!(tx_is_k === 1'b1 && tx_code === `K28_5) && ++n < 10);
		@(negedge core_clk);
		check("idle pair", {tx_is_k, tx_code}, {1'b0, `D16_2});
		$display("done registers and idle");
		for (int k = 0; k < 4; k++) begin
			new_frame(1 + ($random(seed) & 7));
			@(posedge core_clk);
			fork
				begin
					foreach (fr[i]) push(fr[i], i == fr.size() - 1);
					tx_valid <= 1'b0;
				end
				tx_expect(1'b0);
			join
		end
		$display("done transmit frames");
		for (int k = 0; k < 3; k++) rx_frame(1 + ($random(seed) & 7), -1);
		rx_frame(4, 2);
		$display("done receive frames");
		repeat (6) pcs_xcvr_model_i.put(`D16_2, 1'b0, 1'b1);
		n = 0;
		do @(negedge core_clk); while (link_ok !== 1'b0 && ++n < 20);
		check("sync lost", link_ok, 1'b0);
		n = 0;
		do @(negedge core_clk); while (link_ok !== 1'b1 && ++n < 60);
		check("sync regained", link_ok, 1'b1);
		$display("done sync");
		mdio(1'b0, `REG_CTRL, 16'h1000, rd);
		repeat (400) begin
			pcs_xcvr_model_i.put(`K28_5, 1'b1, 1'b0);
			pcs_xcvr_model_i.put(`D21_5, 1'b0, 1'b0);
			pcs_xcvr_model_i.put(8'ha0, 1'b0, 1'b0);
			pcs_xcvr_model_i.put(8'h41, 1'b0, 1'b0);
		end
		check("autoneg busy", link_ok, 1'b0);
		n = 0;
		do @(negedge core_clk); while (link_ok !== 1'b1 && ++n < 6000);
		check("autoneg link", link_ok, 1'b1);
		mdio(1'b1, `REG_LP, 16'h0000, rd);
		check("partner word", rd, 16'h41a0);
		mdio(1'b1, `REG_STAT, 16'h0000, rd);
		check("autoneg done", rd[5], 1'b1);
		$display("done autoneg");
		pcs_xcvr_model_i.set_lock(1'b0);
		repeat (4) @(negedge core_clk);
		check("lock lost", {link_ok, tx_ready, tx_is_k, tx_code}, {3'b011, `K28_5});
		pcs_xcvr_model_i.set_lock(1'b1);
		mdio(1'b1, `REG_CTRL, 16'h0000, rd);
		check("ctrl after lock", rd, `CTRL_RESET);
		$display("done lock");
		tally_and_finish();
	end
endmodule : pcs_sublayer_tb

// *** pcs_xcvr_model.sv ***
// Transceiver model: decoded receive bytes and PLL lock indication
// Assumes it shares core_clk with the sublayer in 8-bit client mode
`timescale 1ns/10ps
`include "pcs_defines.svh"
module pcs_xcvr_model (
	input  wire logic core_clk,
	output logic [7:0] rx_code,
	output logic       rx_is_k,
	output logic       rx_code_err,
	output logic       pll_lock
);
	logic [9:0] q[$];
	logic       ph_r = 1'b0;
	initial begin
		{rx_code_err, rx_is_k, rx_code} = {2'b01, `K28_5};
		pll_lock = 1'b0;
	end
	task automatic put(input logic [7:0] c, input logic k, input logic e);
		q.push_back({e, k, c});
	endtask : put
	task automatic set_lock(input logic v);
		@(posedge core_clk);
		pll_lock <= v;
	endtask : set_lock
	always @(posedge core_clk) begin
		if (q.size() > 0) begin
			{rx_code_err, rx_is_k, rx_code} <= q.pop_front();
		end else begin
			ph_r <= ~ph_r;
			{rx_code_err, rx_is_k, rx_code} <= ph_r ? {2'b00, `D16_2} : {2'b01, `K28_5};
		end
	end
endmodule : pcs_xcvr_model
